// file: rtl/dshp_map.svh
// constants of the display serial host port: pin codes, slots, host registers
// assumes inclusion by bare name from the package and both ends
`ifndef DSHP_MAP_SVH
`define DSHP_MAP_SVH
// board mode pins as {high, low}
`define DSHP_BS_SPI3 2'h1
`define DSHP_BS_SPI4 2'h0
`define DSHP_BS_I2C 2'h2
// upper six bits of the 7-bit slave address
`define DSHP_I2C_ADDR_HI 6'h1E
`define DSHP_SPI_LAST 3'h7
// i2c slot numbering: rises counted, 8 ends the byte, 9 ends the ack
`define DSHP_SLOT_ACK 4'h8
`define DSHP_SLOT_END 4'h9
`define DSHP_SLOT_STEP 4'h1
`define DSHP_CO_BIT 7
`define DSHP_DC_BIT 6
`define DSHP_RW_BIT 0
// host register byte offsets and fields
`define DSHP_REG_CMD 8'h00
`define DSHP_REG_STATUS 8'h04
`define DSHP_REG_CFG 8'h08
`define DSHP_CMD_DC 8
`define DSHP_CMD_OP_HI 11
`define DSHP_CMD_OP_LO 9
`define DSHP_CMD_LAST 12
`define DSHP_DIV_RST 8'h06
`define DSHP_BIT_ACK 4'h8
`define DSHP_BIT_SPI_LAST 4'h7
`define DSHP_BIT_STEP 4'h1
`define DSHP_BYTE_IDLE 8'hFF
`define DSHP_PTR_STEP 8'h01
`endif

// file: rtl/dshp_pkg.sv
// types shared by both ends of the display serial host port
// assumes dshp_map.svh on the include path
`include "dshp_map.svh"
package dshp_pkg;
  typedef logic [7:0] dshp_byte_t;
  typedef struct packed {
    logic cs_n;
    logic spi_clk;
    logic spi_din;
    logic dcs;
    logic scl;
    logic sda;
    logic mode_lo;
    logic mode_hi;
    logic addr_lsb;
  } dshp_pins_t;
  typedef enum logic [1:0] {M_SPI3, M_SPI4, M_I2C, M_OFF} dshp_mode_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CTRL, I_DATA, I_TX, I_SKIP} dshp_i2c_st_t;
  typedef enum logic [3:0] {
    H_IDLE, H_RS1, H_RS2, H_ST1, H_ST2, H_LOW, H_SET, H_HIGH, H_SP1, H_SP2, H_SP3
  } dshp_host_st_t;
  typedef enum logic [2:0] {OP_SPI, OP_START, OP_WRITE, OP_READ, OP_STOP} dshp_op_t;
endpackage

// file: rtl/dshp_if.sv
// link between host controller and display serial port
// sda is open drain: a party pulls low when its oe_n is low and its o is low
`timescale 1ns/10ps
interface dshp_if;
  logic cs_n;
  logic spi_clk;
  logic spi_din;
  logic data_command_select;
  logic i2c_scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
  modport dev (
    input cs_n, spi_clk, spi_din, data_command_select, i2c_scl, sda,
    output dev_sda_o, dev_sda_oe_n
  );
  modport host (
    output cs_n, spi_clk, spi_din, data_command_select, i2c_scl, host_sda_o, host_sda_oe_n,
    input sda
  );
endinterface

// file: rtl/dshp_device.sv
// display end of the serial host port: 3/4-wire write-only spi and i2c slave
// assumes all link pins and straps asynchronous to pclk; sda pulled up outside
`timescale 1ns/10ps
`include "dshp_map.svh"
module dshp_device
  import dshp_pkg::*;
(
  // system
  input logic pclk,
  input logic presetn,
  // link
  dshp_if.dev lnk,
  // board straps
  input logic board_mode_select_low,
  input logic board_mode_select_high,
  input logic address_lsb_select,
  // display side
  input dshp_byte_t status_byte,
  input dshp_byte_t ram_rd_byte,
  output logic ram_we,
  output logic cmd_we,
  output dshp_byte_t wr_byte,
  output dshp_byte_t ram_addr
);
  dshp_pins_t raw;
  dshp_pins_t sync1_r;
  dshp_pins_t s_r;
  dshp_pins_t p_r;
  dshp_mode_t mode;
  logic spi_on;
  logic spi_rise;
  logic spi_wr;
  logic spi_dc;
  dshp_byte_t spi_byte;
  dshp_byte_t spi_sr_r;
  logic [2:0] spi_cnt_r;
  logic i2c_on;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic byte_end;
  logic ack_end;
  logic addr_hit;
  logic i2c_wr;
  logic tx_load;
  dshp_byte_t rd_byte;
  dshp_i2c_st_t ist_r;
  logic [3:0] slot_r;
  dshp_byte_t rx_r;
  dshp_byte_t tx_r;
  logic sda_low_r;
  logic nack_r;
  logic cont_r;
  logic dc_r;
  logic ram_we_r;
  logic cmd_we_r;
  dshp_byte_t wr_byte_r;
  dshp_byte_t ram_addr_r;

  assign raw = '{cs_n: lnk.cs_n, spi_clk: lnk.spi_clk, spi_din: lnk.spi_din,
                 dcs: lnk.data_command_select, scl: lnk.i2c_scl, sda: lnk.sda,
                 mode_lo: board_mode_select_low, mode_hi: board_mode_select_high,
                 addr_lsb: address_lsb_select};

  // every pin through two flops; p_r only keeps the previous settled value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '1;
      s_r <= '1;
      p_r <= '1;
    end else begin
      sync1_r <= raw;
      s_r <= sync1_r;
      p_r <= s_r;
    end
  end

  // straps are read continuously; they are expected to be static
  always_comb begin
    unique case ({s_r.mode_hi, s_r.mode_lo})
      `DSHP_BS_SPI3: mode = M_SPI3;
      `DSHP_BS_SPI4: mode = M_SPI4;
      `DSHP_BS_I2C: mode = M_I2C;
      default: mode = M_OFF;
    endcase
  end

  // spi receiver: level of chip select gates it, so a select held low also works
  assign spi_on = (mode == M_SPI3 || mode == M_SPI4) && !s_r.cs_n;
  assign spi_rise = spi_on && s_r.spi_clk && !p_r.spi_clk;
  assign spi_byte = {spi_sr_r[6:0], s_r.spi_din};
  assign spi_wr = spi_rise && spi_cnt_r == `DSHP_SPI_LAST;
  // 3-wire mode ignores the select pin, so bytes go to the command register
  assign spi_dc = mode == M_SPI4 && s_r.dcs;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_sr_r <= '0;
      spi_cnt_r <= '0;
    end else if (!spi_on) begin
      spi_sr_r <= '0;
      spi_cnt_r <= '0;
    end else if (spi_rise) begin
      spi_sr_r <= spi_byte;
      spi_cnt_r <= spi_cnt_r + 3'h1;
    end
  end

  // i2c slave: no sda output exists on the spi path
  assign i2c_on = mode == M_I2C;
  assign scl_rise = s_r.scl && !p_r.scl;
  assign scl_fall = !s_r.scl && p_r.scl;
  assign start_c = s_r.scl && p_r.scl && p_r.sda && !s_r.sda;
  assign stop_c = s_r.scl && p_r.scl && !p_r.sda && s_r.sda;
  assign byte_end = i2c_on && !start_c && !stop_c && scl_fall && slot_r == `DSHP_SLOT_ACK;
  assign ack_end = i2c_on && !start_c && !stop_c && scl_fall && slot_r == `DSHP_SLOT_END;
  assign addr_hit = rx_r[7:1] == {`DSHP_I2C_ADDR_HI, s_r.addr_lsb};
  assign i2c_wr = byte_end && ist_r == I_DATA;
  assign tx_load = ack_end && ist_r == I_TX && !nack_r;
  assign rd_byte = dc_r ? ram_rd_byte : status_byte;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= I_IDLE;
      slot_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      sda_low_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (!i2c_on || stop_c) begin
      ist_r <= I_IDLE;
      slot_r <= '0;
      sda_low_r <= 1'b0;
    end else if (start_c) begin
      ist_r <= I_ADDR;
      slot_r <= '0;
      sda_low_r <= 1'b0;
    end else if (ist_r == I_IDLE || ist_r == I_SKIP) begin
      // other slaves' traffic: only start or stop wakes us
      slot_r <= '0;
    end else if (scl_rise) begin
      if (slot_r < `DSHP_SLOT_ACK) begin
        rx_r <= {rx_r[6:0], s_r.sda};
      end else if (ist_r == I_TX) begin
        nack_r <= s_r.sda;
      end
      slot_r <= slot_r + `DSHP_SLOT_STEP;
    end else if (scl_fall) begin
      if (slot_r == `DSHP_SLOT_ACK) begin
        unique case (ist_r)
          I_ADDR: begin
            if (addr_hit) begin
              sda_low_r <= 1'b1;
              nack_r <= 1'b0;
              ist_r <= rx_r[`DSHP_RW_BIT] ? I_TX : I_CTRL;
            end else begin
              ist_r <= I_SKIP;
            end
          end
          I_CTRL: begin
            sda_low_r <= 1'b1;
            ist_r <= I_DATA;
          end
          I_DATA: begin
            sda_low_r <= 1'b1;
            ist_r <= cont_r ? I_CTRL : I_DATA;
          end
          I_TX: sda_low_r <= 1'b0;
          I_IDLE, I_SKIP: sda_low_r <= 1'b0;
        endcase
      end else if (slot_r == `DSHP_SLOT_END) begin
        slot_r <= '0;
        if (tx_load) begin
          tx_r <= {rd_byte[6:0], 1'b0};
          sda_low_r <= !rd_byte[7];
        end else if (ist_r == I_TX) begin
          ist_r <= I_SKIP;
          sda_low_r <= 1'b0;
        end else begin
          sda_low_r <= 1'b0;
        end
      end else if (ist_r == I_TX && slot_r != '0) begin
        sda_low_r <= !tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // control byte: the data/command flag persists, so a later read uses it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_r <= 1'b0;
      dc_r <= 1'b0;
    end else if (byte_end && ist_r == I_CTRL) begin
      cont_r <= rx_r[`DSHP_CO_BIT];
      dc_r <= rx_r[`DSHP_DC_BIT];
    end
  end

  // write port shared by both links; only one is active for a given strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_we_r <= 1'b0;
      cmd_we_r <= 1'b0;
      wr_byte_r <= '0;
    end else begin
      ram_we_r <= (spi_wr && spi_dc) || (i2c_wr && dc_r);
      cmd_we_r <= (spi_wr && !spi_dc) || (i2c_wr && !dc_r);
      if (spi_wr) begin
        wr_byte_r <= spi_byte;
      end else if (i2c_wr) begin
        wr_byte_r <= rx_r;
      end
    end
  end

  // pointer moves after the write strobe, so the address is stable during it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr_r <= '0;
    end else if (ram_we_r || (tx_load && dc_r)) begin
      ram_addr_r <= ram_addr_r + `DSHP_PTR_STEP;
    end
  end

  assign lnk.dev_sda_o = 1'b0;
  assign lnk.dev_sda_oe_n = !sda_low_r;
  assign ram_we = ram_we_r;
  assign cmd_we = cmd_we_r;
  assign wr_byte = wr_byte_r;
  assign ram_addr = ram_addr_r;
endmodule

// file: rtl/dshp_host.sv
// host end: apb-programmed controller that drives spi bytes or i2c bit traffic
// assumes an apb master that waits on pready; sda is open drain with a pull-up outside
`timescale 1ns/10ps
`include "dshp_map.svh"
module dshp_host
  import dshp_pkg::*;
(
  // system
  input logic pclk,
  input logic presetn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  dshp_if.host lnk
);
  dshp_host_st_t hst_r;
  logic busy;
  logic cmd_wr;
  logic tick;
  logic [7:0] div_r;
  logic [7:0] cnt_r;
  logic [31:0] prdata_r;
  dshp_byte_t sh_r;
  dshp_byte_t rx_r;
  logic [3:0] bit_r;
  logic spi_r;
  logic writing_r;
  logic last_r;
  logic nack_r;
  logic cs_n_r;
  logic dcs_r;
  logic sclk_r;
  logic din_r;
  logic scl_r;
  logic sda_low_r;
  logic sda_m_r;
  logic sda_s_r;
  dshp_op_t op;

  assign busy = hst_r != H_IDLE;
  // a new command stalls in the access phase until the engine is free
  assign pready = !(pwrite && paddr[7:0] == `DSHP_REG_CMD && busy);
  assign pslverr = 1'b0;
  assign cmd_wr = psel && penable && pwrite && pready && paddr[7:0] == `DSHP_REG_CMD;
  assign op = dshp_op_t'(pwdata[`DSHP_CMD_OP_HI:`DSHP_CMD_OP_LO]);
  assign tick = busy && cnt_r == '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= lnk.sda;
      sda_s_r <= sda_m_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= `DSHP_DIV_RST;
    end else if (psel && penable && pwrite && paddr[7:0] == `DSHP_REG_CFG) begin
      div_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      unique case (paddr[7:0])
        `DSHP_REG_STATUS: prdata_r <= {16'h0000, rx_r, 6'h00, nack_r, busy};
        `DSHP_REG_CFG: prdata_r <= {24'h000000, div_r};
        default: prdata_r <= '0;
      endcase
    end
  end
  assign prdata = prdata_r;

  // half-phase divider for the link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!busy || cnt_r == '0) begin
      cnt_r <= div_r;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hst_r <= H_IDLE;
      sh_r <= '0;
      rx_r <= '0;
      bit_r <= '0;
      spi_r <= 1'b0;
      writing_r <= 1'b0;
      last_r <= 1'b0;
      nack_r <= 1'b0;
      cs_n_r <= 1'b1;
      dcs_r <= 1'b0;
      sclk_r <= 1'b0;
      din_r <= 1'b0;
      scl_r <= 1'b1;
      sda_low_r <= 1'b0;
    end else if (hst_r == H_IDLE) begin
      if (cmd_wr) begin
        bit_r <= '0;
        last_r <= pwdata[`DSHP_CMD_LAST];
        sh_r <= pwdata[7:0];
        writing_r <= 1'b1;
        spi_r <= 1'b0;
        unique case (op)
          OP_SPI: begin
            spi_r <= 1'b1;
            cs_n_r <= 1'b0;
            dcs_r <= pwdata[`DSHP_CMD_DC];
            hst_r <= H_LOW;
          end
          OP_START: hst_r <= scl_r ? H_ST1 : H_RS1;
          OP_WRITE: hst_r <= H_LOW;
          OP_READ: begin
            writing_r <= 1'b0;
            sh_r <= `DSHP_BYTE_IDLE;
            hst_r <= H_LOW;
          end
          OP_STOP: hst_r <= H_SP1;
          default: hst_r <= H_IDLE;
        endcase
      end
    end else if (tick) begin
      unique case (hst_r)
        H_RS1: begin
          sda_low_r <= 1'b0;
          hst_r <= H_RS2;
        end
        H_RS2: begin
          scl_r <= 1'b1;
          hst_r <= H_ST1;
        end
        H_ST1: begin
          if (sda_s_r) begin
            sda_low_r <= 1'b1;
            hst_r <= H_ST2;
          end
        end
        H_ST2: begin
          scl_r <= 1'b0;
          hst_r <= H_LOW;
        end
        H_LOW: begin
          if (spi_r) begin
            din_r <= sh_r[7];
          end else if (bit_r < `DSHP_BIT_ACK) begin
            sda_low_r <= writing_r && !sh_r[7];
          end else begin
            sda_low_r <= !writing_r && !last_r;
          end
          hst_r <= H_SET;
        end
        H_SET: begin
          sclk_r <= spi_r;
          scl_r <= !spi_r;
          hst_r <= H_HIGH;
        end
        H_HIGH: begin
          if (bit_r < `DSHP_BIT_ACK) begin
            sh_r <= {sh_r[6:0], sda_s_r};
          end else begin
            nack_r <= sda_s_r;
            rx_r <= sh_r;
          end
          sclk_r <= 1'b0;
          scl_r <= spi_r;
          bit_r <= bit_r + `DSHP_BIT_STEP;
          if (spi_r && bit_r == `DSHP_BIT_SPI_LAST) begin
            cs_n_r <= last_r;
            hst_r <= H_IDLE;
          end else if (!spi_r && bit_r == `DSHP_BIT_ACK) begin
            hst_r <= last_r ? H_SP1 : H_IDLE;
          end else begin
            hst_r <= H_LOW;
          end
        end
        H_SP1: begin
          sda_low_r <= 1'b1;
          hst_r <= H_SP2;
        end
        H_SP2: begin
          scl_r <= 1'b1;
          hst_r <= H_SP3;
        end
        H_SP3: begin
          sda_low_r <= 1'b0;
          hst_r <= H_IDLE;
        end
        H_IDLE: hst_r <= H_IDLE;
      endcase
    end
  end

  assign lnk.cs_n = cs_n_r;
  assign lnk.spi_clk = sclk_r;
  assign lnk.spi_din = din_r;
  assign lnk.data_command_select = dcs_r;
  assign lnk.i2c_scl = scl_r;
  assign lnk.host_sda_o = 1'b0;
  assign lnk.host_sda_oe_n = !sda_low_r;
endmodule

// file: verif/dshp_properties.sv
// checker: wire-level properties of the link between host end and display end
// assumes link signals sampled on pclk and the host divider left at its reset value 6
`timescale 1ns/10ps
module dshp_properties (
  // system
  input logic pclk,
  input logic presetn,
  // link
  input logic cs_n,
  input logic spi_clk,
  input logic spi_din,
  input logic data_command_select,
  input logic i2c_scl,
  input logic host_sda_o,
  input logic host_sda_oe_n,
  input logic dev_sda_o,
  input logic dev_sda_oe_n,
  input logic sda
);
  logic [2:0] spi_cnt_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // rises counted mod 8 per frame; a frame must close on a byte boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_cnt_r <= 3'h0;
    end else if (cs_n) begin
      spi_cnt_r <= 3'h0;
    end else if ($rose(spi_clk)) begin
      spi_cnt_r <= spi_cnt_r + 3'h1;
    end
  end

  spi_idle_a: assert property (cs_n |-> !spi_clk)
    else $error("spi clock high while deselected");
  spi_rise_sel_a: assert property ($rose(spi_clk) |-> !cs_n)
    else $error("spi clock rise outside a frame");
  spi_data_hold_a: assert property ($rose(spi_clk) |->
    $stable(spi_din) && $stable(data_command_select))
    else $error("spi data moved at clock rise");
  spi_high_len_a: assert property ($rose(spi_clk) |-> spi_clk [*7] ##1 !spi_clk)
    else $error("spi clock high phase length wrong");
  spi_byte_whole_a: assert property ($rose(cs_n) |-> spi_cnt_r == 3'h0)
    else $error("spi frame closed mid byte");
  sda_dev_low_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
    else $error("device drives sda high");
  sda_dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !i2c_scl)
    else $error("device moved sda while scl high");
  sda_start_src_a: assert property ($fell(sda) && i2c_scl && $past(i2c_scl) |-> dev_sda_oe_n)
    else $error("device made a start condition");
  // only a start pulls sda while scl is high; the bus must have been idle just before
  bus_idle_start_a: assert property ($fell(host_sda_oe_n) && i2c_scl |->
    $past(sda) && $past(i2c_scl) && !host_sda_o)
    else $error("host started on a busy bus");
  scl_high_len_a: assert property ($rose(i2c_scl) |-> i2c_scl [*7])
    else $error("scl high phase too short");
endmodule

// file: verif/tb_top.sv
// testbench: host end programmed over apb, display end watched at its outputs
// assumes both ends joined by dshp_if; host divider left at its reset value
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mode_lo = 1'b0;
  logic mode_hi = 1'b0;
  logic addr_lsb = 1'b0;
  logic [7:0] status_byte = 8'h00;
  logic [7:0] ram_rd_byte = 8'h00;
  logic [7:0] wr_byte;
  logic [7:0] ram_addr;
  logic ram_we;
  logic cmd_we;
  logic [17:0] exp_q[$];
  logic [17:0] n;
  logic [7:0] ptr = 8'h00;
  logic [31:0] st;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  dshp_if lnk();
  always #5 pclk = ~pclk;

  dshp_host u_dshp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  dshp_device u_dshp_device (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .board_mode_select_low(mode_lo), .board_mode_select_high(mode_hi),
    .address_lsb_select(addr_lsb), .status_byte(status_byte), .ram_rd_byte(ram_rd_byte),
    .ram_we(ram_we), .cmd_we(cmd_we), .wr_byte(wr_byte), .ram_addr(ram_addr));
  dshp_properties u_dshp_properties (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n),
    .spi_clk(lnk.spi_clk), .spi_din(lnk.spi_din), .data_command_select(lnk.data_command_select),
    .i2c_scl(lnk.i2c_scl), .host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n),
    .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe_n(lnk.dev_sda_oe_n), .sda(lnk.sda));

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic results();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // entered just after a rising edge; request held until pready seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // status polled until the engine is idle
  task automatic idle();
    st = 32'h1;
    while (st[0] !== 1'b0) apb(1'b0, 32'h4, 32'h0, st);
  endtask

  // one link operation, then wait for the engine
  task automatic run(input logic [2:0] op, input logic dc, input logic last, input logic [7:0] b);
    logic [31:0] r;
    apb(1'b1, 32'h0, {19'h0, last, op, dc, b}, r);
    idle();
  endtask

  task automatic note(input logic ram, input logic [7:0] b);
    exp_q.push_back({ram, !ram, ram ? ptr : 8'h00, b});
    if (ram) ptr = ptr + 8'h01;
  endtask

  task automatic ack(input logic e);
    chk("nack flag", {31'h0, e}, {31'h0, st[1]});
  endtask

  // straps are sampled live through a synchroniser, so settle before traffic
  task automatic mode(input logic [1:0] m);
    {mode_hi, mode_lo} <= m;
    repeat (8) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (presetn === 1'b1 && (ram_we === 1'b1 || cmd_we === 1'b1)) begin
      n = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h0;
      chk("display write", {14'h0, n},
          {14'h0, ram_we, cmd_we, ram_we ? ram_addr : 8'h00, wr_byte});
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  initial begin
    logic [31:0] r;
    logic [7:0] b;
    logic a;
    int i;
    void'($urandom(9));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, 32'h10, 32'hFFFFFFFF, r);
    apb(1'b0, 32'h8, 32'h0, r);
    chk("cfg divider", 32'h6, r);
    apb(1'b0, 32'h10, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    // 4-wire: one held-low frame; later commands stall on pready while busy
    for (i = 0; i < 4; i++) begin
      b = 8'($urandom);
      note(i[0], b);
      apb(1'b1, 32'h0, {19'h0, i == 3, 3'h0, i[0], b}, r);
    end
    idle();
    mode(2'h1);
    b = 8'($urandom);
    note(1'b0, b);
    run(3'h0, 1'b1, 1'b1, b);
    mode(2'h3);
    run(3'h0, 1'b1, 1'b1, 8'($urandom));
    mode(2'h2);
    a = 1'($urandom);
    addr_lsb <= a;
    repeat (4) @(posedge pclk);
    run(3'h1, 1'b0, 1'b0, {6'h1E, a, 1'b0});
    ack(1'b0);
    run(3'h2, 1'b0, 1'b0, 8'hC0);
    ack(1'b0);
    b = 8'($urandom);
    note(1'b1, b);
    run(3'h2, 1'b0, 1'b0, b);
    ack(1'b0);
    run(3'h2, 1'b0, 1'b0, 8'h3F);
    ack(1'b0);
    for (i = 0; i < 2; i++) begin
      b = 8'($urandom);
      note(1'b0, b);
      run(3'h2, 1'b0, i == 1, b);
      ack(1'b0);
    end
    status_byte <= 8'($urandom);
    run(3'h1, 1'b0, 1'b0, {6'h1E, a, 1'b1});
    ack(1'b0);
    run(3'h3, 1'b0, 1'b1, 8'h00);
    ack(1'b1);
    chk("status read", {24'h0, status_byte}, {24'h0, st[15:8]});
    run(3'h1, 1'b0, 1'b0, {6'h1E, a, 1'b0});
    run(3'h2, 1'b0, 1'b0, 8'h40);
    b = 8'($urandom);
    note(1'b1, b);
    run(3'h2, 1'b0, 1'b1, b);
    ack(1'b0);
    ram_rd_byte <= 8'($urandom);
    run(3'h1, 1'b0, 1'b0, {6'h1E, a, 1'b1});
    // acked byte reloads the next one; both loads move the pointer
    ptr = ptr + 8'h02;
    run(3'h3, 1'b0, 1'b0, 8'h00);
    ack(1'b0);
    chk("ram read", {24'h0, ram_rd_byte}, {24'h0, st[15:8]});
    run(3'h3, 1'b0, 1'b1, 8'h00);
    ack(1'b1);
    chk("ram read", {24'h0, ram_rd_byte}, {24'h0, st[15:8]});
    // other address: no ack and no display write for the whole transfer
    run(3'h1, 1'b0, 1'b0, {6'h1E, ~a, 1'b0});
    ack(1'b1);
    run(3'h2, 1'b0, 1'b0, 8'h40);
    ack(1'b1);
    run(3'h2, 1'b0, 1'b0, 8'($urandom));
    run(3'h4, 1'b0, 1'b0, 8'h00);
    run(3'h1, 1'b0, 1'b0, {6'h1E, a, 1'b0});
    run(3'h2, 1'b0, 1'b0, 8'h40);
    b = 8'($urandom);
    note(1'b1, b);
    run(3'h2, 1'b0, 1'b1, b);
    repeat (20) @(posedge pclk);
    chk("writes left", 32'h0, 32'(exp_q.size()));
    results();
  end
endmodule
